// ===== dcf_fifo.sv
// 256 x 18 fifo with strobe pins, level flags and axi4-lite status port
//
// Behaviour
// - a write strobe rising edge stores the input word unless full.
// - a read strobe rising edge presents the next word unless empty.
// - full when writes exceed reads by 256; full flag low then.
// - write edges while full change neither contents nor write pointer.
// - empty flag low with no words held, high otherwise.
// - read edges while empty change neither read pointer nor output.
// - half-level flag high at 128 words or more, low below.
// - threshold flag high at count <= low offset or >= 256 - high.
// - reset clears pointers; full high, threshold high, half low, empty low.
// - read data level after reset is not defined.
// - first word into empty queue shows on read data, empty goes high.
// - output enable high puts read data in high impedance.
// - first program edge after reset loads both offsets from low byte.
// - second program edge reloads only the high offset.
// - program edges neither store words nor move the write pointer.
// - programming only before first stored word; enable ignored after.
// - with program enable high both offsets take the default value.
// - strobes may be asynchronous or identical.
// - 18-bit write and read ports, storage for 256 words.
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module dcf_fifo #(
	parameter int unsigned DW = dcf_pkg::DATA_W,
	parameter int unsigned AW = dcf_pkg::ADDR_W
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic write_strobe_i,
	input wire logic [DW-1:0] write_data_i,
	input wire logic read_strobe_i,
	input wire logic output_enable_n_i,
	input wire logic offset_program_enable_n_i,
	output logic [DW-1:0] read_data_o,
	output logic read_data_oe_o,
	output logic full_n_o,
	output logic empty_n_o,
	output logic half_level_flag_o,
	output logic threshold_flag_o,
	input wire logic [7:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [7:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i
);

	localparam int CW = AW + 1;
	localparam logic [CW-1:0] DEPTH_C = CW'(1) << AW;
	localparam logic [CW-1:0] HALF_C = CW'(1) << (AW - 1);
	localparam logic [CW-1:0] ONE_C = CW'(1);

	// level flags of a given word count and offsets
	function automatic dcf_pkg::dcf_flags_s flags_of(
		input logic [CW-1:0] c,
		input logic [7:0] x,
		input logic [7:0] y
	);
		dcf_pkg::dcf_flags_s f;
		logic [CW-1:0] hi;
		hi = DEPTH_C - CW'(y);
		f.empty_n = (c != '0);
		f.full_n = (c != DEPTH_C);
		f.half = (c >= HALF_C);
		f.thresh = (c <= CW'(x)) || (c >= hi);
		return f;
	endfunction

	// pin inputs: three flops, level follows once stages two and three agree
	dcf_pkg::dcf_pins_s pin_s1_r, pin_s2_r, pin_s3_r, pin_lvl_r;
	dcf_pkg::dcf_pins_s pin_lvl_nxt;
	logic [DW-1:0] wd_s1_r, wd_s2_r, wd_s3_r;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			pin_s1_r <= dcf_pkg::PINS_RST;
			pin_s2_r <= dcf_pkg::PINS_RST;
			pin_s3_r <= dcf_pkg::PINS_RST;
			pin_lvl_r <= dcf_pkg::PINS_RST;
		end else begin
			pin_s1_r <= {offset_program_enable_n_i, output_enable_n_i,
				read_strobe_i, write_strobe_i};
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
			pin_lvl_r <= pin_lvl_nxt;
		end
	end

	// data rides beside the strobe so the word sampled matches its edge
	always_ff @(posedge clk_i) begin
		wd_s1_r <= write_data_i;
		wd_s2_r <= wd_s1_r;
		wd_s3_r <= wd_s2_r;
	end

	assign pin_lvl_nxt = (pin_s2_r & pin_s3_r) |
		(pin_lvl_r & (pin_s2_r | pin_s3_r));

	// both strobes are resampled on clk_i, so any phase relation works
	wire wr_rise = pin_lvl_nxt.wr & ~pin_lvl_r.wr;
	wire rd_rise = pin_lvl_nxt.rd & ~pin_lvl_r.rd;
	wire [DW-1:0] wd = wd_s3_r;

	// queue state
	logic [DW-1:0] mem [0:(1<<AW)-1];
	logic [AW-1:0] wptr_r, rptr_r;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic [DW-1:0] rdata_r;
	logic [7:0] x_r, y_r;
	dcf_pkg::dcf_prog_e prog_r, prog_nxt;
	dcf_pkg::dcf_flags_s flags_r;
	logic soft_clr_r, clr_d_r;

	wire clr = srst_i | soft_clr_r;
	wire prog_open = (prog_r != dcf_pkg::PROG_DONE);
	// a program edge is swallowed and never becomes a stored word
	wire prog_edge = wr_rise & ~pin_lvl_r.pen_n & prog_open;
	wire wr_acc = wr_rise & ~prog_edge & flags_r.full_n;
	wire rd_acc = rd_rise & flags_r.empty_n;
	wire [AW-1:0] rptr_inc = rptr_r + AW'(1);

	always_comb begin
		cnt_nxt = cnt_r;
		if (wr_acc && !rd_acc) begin
			cnt_nxt = cnt_r + ONE_C;
		end else if (rd_acc && !wr_acc) begin
			cnt_nxt = cnt_r - ONE_C;
		end
	end

	always_comb begin
		prog_nxt = prog_r;
		if (wr_acc) begin
			prog_nxt = dcf_pkg::PROG_DONE;
		end else if (prog_edge) begin
			prog_nxt = (prog_r == dcf_pkg::PROG_OPEN) ?
				dcf_pkg::PROG_ONE : dcf_pkg::PROG_DONE;
		end
	end

	always_ff @(posedge clk_i) begin
		if (wr_acc) begin
			mem[wptr_r] <= wd;
		end
	end

	always_ff @(posedge clk_i) begin
		if (clr) begin
			wptr_r <= dcf_pkg::PTR_RST;
			rptr_r <= dcf_pkg::PTR_RST;
			cnt_r <= dcf_pkg::CNT_RST;
			flags_r <= dcf_pkg::FLAGS_RST;
			prog_r <= dcf_pkg::PROG_OPEN;
		end else begin
			if (wr_acc) begin
				wptr_r <= wptr_r + AW'(1);
			end
			if (rd_acc) begin
				rptr_r <= rptr_inc;
			end
			cnt_r <= cnt_nxt;
			flags_r <= flags_of(cnt_nxt, x_r, y_r);
			prog_r <= prog_nxt;
		end
	end

	// offsets: defaults stand unless the writer programs them
	always_ff @(posedge clk_i) begin
		if (clr) begin
			x_r <= dcf_pkg::DEF_OFFSET;
			y_r <= dcf_pkg::DEF_OFFSET;
		end else if (prog_edge) begin
			if (prog_r == dcf_pkg::PROG_OPEN) begin
				x_r <= wd[7:0];
			end
			y_r <= wd[7:0];
		end
	end

	// head word register; a word written into an empty or draining queue
	// is forwarded because the memory read would see the old contents
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rdata_r <= dcf_pkg::DATA_RST;
		end else if (wr_acc && cnt_r == '0) begin
			rdata_r <= wd;
		end else if (rd_acc) begin
			if (cnt_r != ONE_C) begin
				rdata_r <= mem[rptr_inc];
			end else if (wr_acc) begin
				rdata_r <= wd;
			end
		end
	end

	assign read_data_o = rdata_r;
	assign read_data_oe_o = ~pin_lvl_r.oe_n;
	assign full_n_o = flags_r.full_n;
	assign empty_n_o = flags_r.empty_n;
	assign half_level_flag_o = flags_r.half;
	assign threshold_flag_o = flags_r.thresh;

	// axi4-lite slave: address and data are caught in either order
	logic aw_held_r, w_held_r, bvalid_r, rvalid_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r, rdata_bus_r;
	logic [3:0] wstrb_r;
	logic [1:0] bresp_r, rresp_r;

	wire aw_hs = s_axi_awvalid_i & ~aw_held_r;
	wire w_hs = s_axi_wvalid_i & ~w_held_r;
	wire do_write = aw_held_r & w_held_r & ~bvalid_r;
	wire ar_hs = s_axi_arvalid_i & ~rvalid_r;
	wire wr_ctrl = (awaddr_r == dcf_pkg::REG_CTRL);
	wire clr_req = do_write & wr_ctrl & wstrb_r[0] &
		wdata_r[dcf_pkg::CTRL_CLR_BIT];

	wire [31:0] status_word = {14'h0000, prog_r, flags_r,
		{(12 - CW){1'b0}}, cnt_r};
	wire [31:0] offset_word = {16'h0000, y_r, x_r};
	wire rd_status = (s_axi_araddr_i == dcf_pkg::REG_STATUS);
	wire rd_offsets = (s_axi_araddr_i == dcf_pkg::REG_OFFSETS);
	wire rd_ctrl = (s_axi_araddr_i == dcf_pkg::REG_CTRL);
	wire rd_known = rd_status | rd_offsets | rd_ctrl;
	wire [31:0] rd_mux = rd_status ? status_word :
		rd_offsets ? offset_word : dcf_pkg::WORD_RST;

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= dcf_pkg::RESP_OKAY;
			awaddr_r <= 8'h00;
			wdata_r <= dcf_pkg::WORD_RST;
			wstrb_r <= 4'h0;
			soft_clr_r <= 1'b0;
		end else begin
			soft_clr_r <= clr_req;
			if (aw_hs) begin
				aw_held_r <= 1'b1;
				awaddr_r <= s_axi_awaddr_i;
			end
			if (w_hs) begin
				w_held_r <= 1'b1;
				wdata_r <= s_axi_wdata_i;
				wstrb_r <= s_axi_wstrb_i;
			end
			if (do_write) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= wr_ctrl ? dcf_pkg::RESP_OKAY :
					dcf_pkg::RESP_SLVERR;
			end else if (bvalid_r && s_axi_bready_i) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			rvalid_r <= 1'b0;
			rdata_bus_r <= dcf_pkg::WORD_RST;
			rresp_r <= dcf_pkg::RESP_OKAY;
		end else if (ar_hs) begin
			rvalid_r <= 1'b1;
			rdata_bus_r <= rd_mux;
			rresp_r <= rd_known ? dcf_pkg::RESP_OKAY :
				dcf_pkg::RESP_SLVERR;
		end else if (rvalid_r && s_axi_rready_i) begin
			rvalid_r <= 1'b0;
		end
	end

	assign s_axi_awready_o = ~aw_held_r;
	assign s_axi_wready_o = ~w_held_r;
	assign s_axi_bvalid_o = bvalid_r;
	assign s_axi_bresp_o = bresp_r;
	assign s_axi_arready_o = ~rvalid_r;
	assign s_axi_rvalid_o = rvalid_r;
	assign s_axi_rdata_o = rdata_bus_r;
	assign s_axi_rresp_o = rresp_r;

	// checks
	// held one cycle past a clear so no $past or $stable spans the clear
	always_ff @(posedge clk_i) begin
		clr_d_r <= clr;
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (clr || clr_d_r);

	a_full_no_store: assert property (
		wr_rise && !flags_r.full_n |=> $stable(wptr_r)
	) else $error("write pointer moved while full");

	a_empty_no_read: assert property (
		rd_rise && !flags_r.empty_n && !wr_acc
			|=> $stable(rptr_r) && $stable(rdata_r)
	) else $error("read acted on an empty queue");

	a_full_flag_level: assert property (
		full_n_o == (cnt_r != DEPTH_C)
	) else $error("full flag disagrees with count");

	a_empty_flag_level: assert property (
		empty_n_o == (cnt_r != '0)
	) else $error("empty flag disagrees with count");

	a_half_flag_level: assert property (
		half_level_flag_o == (cnt_r >= HALF_C)
	) else $error("half-level flag disagrees with count");

	a_thresh_flag_level: assert property (
		threshold_flag_o == ((cnt_r <= CW'(x_r)) ||
			(cnt_r >= DEPTH_C - CW'(y_r)))
	) else $error("threshold flag disagrees with offsets");

	a_first_word_shown: assert property (
		wr_acc && cnt_r == '0
			|=> read_data_o == $past(wd) && empty_n_o
	) else $error("first word not presented");

	a_prog_no_store: assert property (
		prog_edge |=> $stable(wptr_r) && cnt_r <= $past(cnt_r)
	) else $error("program edge stored a word");

	a_prog_first_load: assert property (
		prog_edge && prog_r == dcf_pkg::PROG_OPEN
			|=> x_r == $past(wd[7:0]) && y_r == $past(wd[7:0])
	) else $error("first program edge did not load offsets");

	a_prog_second_load: assert property (
		prog_edge && prog_r == dcf_pkg::PROG_ONE
			|=> $stable(x_r) && y_r == $past(wd[7:0])
	) else $error("second program edge mishandled offsets");

	a_pen_ignored_late: assert property (
		prog_r == dcf_pkg::PROG_DONE |=> $stable(x_r) && $stable(y_r)
	) else $error("offsets changed after first word");

	a_oe_releases_bus: assert property (
		pin_s2_r.oe_n && pin_s3_r.oe_n |=> !read_data_oe_o
	) else $error("read data driven while disabled");

	a_reset_flags: assert property (
		@(posedge clk_i) disable iff (1'b0)
		srst_i |=> full_n_o && threshold_flag_o && !half_level_flag_o
			&& !empty_n_o && wptr_r == '0 && rptr_r == '0
	) else $error("reset did not set flag levels");

endmodule

// ===== dcf_pkg.sv
// shared constants, types and register map of the dual-strobe fifo
package dcf_pkg;

	// storage geometry
	localparam int unsigned DATA_W = 18;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned OFF_W = 8;

	// register byte offsets on the axi4-lite port
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_OFFSETS = 8'h04;
	localparam logic [7:0] REG_CTRL = 8'h08;

	// field positions
	localparam int unsigned CTRL_CLR_BIT = 0;
	localparam int unsigned ST_FLAGS_LSB = 12;
	localparam int unsigned ST_PROG_LSB = 16;
	localparam int unsigned OFS_HIGH_LSB = 8;

	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// threshold offset used when programming is skipped
	localparam logic [7:0] DEF_OFFSET = 8'h40;

	typedef struct packed {
		logic thresh;
		logic half;
		logic full_n;
		logic empty_n;
	} dcf_flags_s;

	typedef struct packed {
		logic pen_n;
		logic oe_n;
		logic rd;
		logic wr;
	} dcf_pins_s;

	typedef enum logic [1:0] {
		PROG_OPEN,
		PROG_ONE,
		PROG_DONE
	} dcf_prog_e;

	// values after reset
	localparam dcf_flags_s FLAGS_RST = 4'ha;
	localparam dcf_pins_s PINS_RST = 4'hc;
	localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
	localparam logic [ADDR_W-1:0] PTR_RST = 8'h00;
	localparam logic [ADDR_W:0] CNT_RST = 9'h000;
	localparam logic [31:0] WORD_RST = 32'h00000000;

endpackage

// ===== dcf_pin_model.sv
// pin-level model of the writing and reading parties on the strobe port
`timescale 1ns/1ps
module dcf_pin_model (
	input wire logic clk_i,
	output logic write_strobe_o,
	output logic [17:0] write_data_o,
	output logic read_strobe_o
);
	initial begin
		write_strobe_o = 1'b0;
		write_data_o = 18'h00000;
		read_strobe_o = 1'b0;
	end
	// four cycles high and low keep each edge clear of the input filter
	task automatic load(input logic [17:0] d);
		@(posedge clk_i);
		write_data_o <= d;
		write_strobe_o <= 1'b1;
		repeat (4) @(posedge clk_i);
		write_strobe_o <= 1'b0;
		// hold time over: the bus no longer shows the word
		write_data_o <= ~d;
		repeat (4) @(posedge clk_i);
	endtask
	task automatic unload();
		@(posedge clk_i);
		read_strobe_o <= 1'b1;
		repeat (4) @(posedge clk_i);
		read_strobe_o <= 1'b0;
		repeat (4) @(posedge clk_i);
	endtask
endmodule

// ===== dcf_fifo_tb.sv
// self-checking bench for the strobe fifo and its axi4-lite status port
`timescale 1ns/1ps
module dcf_fifo_tb;
	typedef struct packed {
		logic [8:0] ld;
		logic [8:0] ul;
		logic [8:0] cnt;
	} dcf_row_s;
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic oe_n = 1'b1;
	logic pen_n = 1'b1;
	wire ws, rs, oe, full_n, empty_n, half, thr, awrdy, wrdy, bv, arrdy, rv;
	wire [17:0] wd, rd;
	wire [1:0] bresp, rresp;
	wire [31:0] rdat;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h00000000;
	logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
	int fail_count = 0;
	int num_checks = 0;
	int cyc = 0;
	logic [17:0] q[$];
	logic [17:0] dat = 18'h2c3a1;
	logic [1:0] resp;
	logic [31:0] word;
	dcf_row_s rows [0:12] = '{'{9'h001, 9'h000, 9'h001},
		'{9'h004, 9'h000, 9'h005}, '{9'h001, 9'h000, 9'h006},
		'{9'h002, 9'h002, 9'h006}, '{9'h079, 9'h000, 9'h07f},
		'{9'h001, 9'h000, 9'h080}, '{9'h075, 9'h000, 9'h0f5},
		'{9'h001, 9'h000, 9'h0f6}, '{9'h00a, 9'h000, 9'h100},
		'{9'h001, 9'h000, 9'h100}, '{9'h000, 9'h001, 9'h0ff},
		'{9'h000, 9'h0ff, 9'h000}, '{9'h000, 9'h001, 9'h000}};

	initial begin
		forever #2 clk_i = ~clk_i;
	end

	dcf_pin_model pm (.clk_i(clk_i), .write_strobe_o(ws),
		.write_data_o(wd), .read_strobe_o(rs));

	dcf_fifo uut (.clk_i(clk_i), .srst_i(srst_i), .write_strobe_i(ws),
		.write_data_i(wd), .read_strobe_i(rs), .output_enable_n_i(oe_n),
		.offset_program_enable_n_i(pen_n), .read_data_o(rd),
		.read_data_oe_o(oe), .full_n_o(full_n), .empty_n_o(empty_n),
		.half_level_flag_o(half), .threshold_flag_o(thr),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awv),
		.s_axi_awready_o(awrdy), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
		.s_axi_arvalid_i(arv), .s_axi_arready_o(arrdy),
		.s_axi_rdata_o(rdat), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rv), .s_axi_rready_i(rready));

	// flags packed as {threshold, half, full_n, empty_n}
	function automatic logic [3:0] ef(input int n, input int x, input int y);
		return {(n <= x) || (n >= 256 - y), n >= 128, n != 256, n != 0};
	endfunction

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk_f(input logic [3:0] e);
		num_checks++;
		if ({thr, half, full_n, empty_n} !== e) begin
			fail_count++;
			$display("BAD %0t flags %h want %h", $time,
				{thr, half, full_n, empty_n}, e);
		end
	endtask

	task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %0t value %h want %h", $time, g, e);
		end
	endtask

	// handshakes are judged from values settled 1 ns after the edge
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		@(posedge clk_i);
		awaddr <= a;
		wdata <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= 1'b1;
		do begin
			#1;
			ta = awv && awrdy;
			tw = wv && wrdy;
			tb = bv;
			resp = bresp;
			@(posedge clk_i);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
		end while (!tb);
		bready <= 1'b0;
	endtask

	task automatic axr(input logic [7:0] a);
		logic ta, tr;
		@(posedge clk_i);
		araddr <= a;
		arv <= 1'b1;
		rready <= 1'b1;
		do begin
			#1;
			ta = arv && arrdy;
			tr = rv;
			word = rdat;
			resp = rresp;
			@(posedge clk_i);
			if (ta) arv <= 1'b0;
		end while (!tr);
		rready <= 1'b0;
	endtask

	// about 5000 cycles are needed; the ceiling leaves ample margin
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			conclude();
		end
	end

	initial begin
		repeat (4) @(posedge clk_i);
		srst_i <= 1'b0;
		oe_n <= 1'b0;
		repeat (6) @(posedge clk_i);
		chk_f(ef(0, 64, 64));
		chk_w({31'h0, oe}, 32'h00000001);
		$display("test reset done");
		pen_n <= 1'b0; // both offsets stay at or below 127
		repeat (5) @(posedge clk_i);
		pm.load(18'h3ff05);
		pm.load(18'h2a50a);
		pen_n <= 1'b1;
		repeat (4) @(posedge clk_i);
		chk_f(ef(0, 5, 10));
		axr(dcf_pkg::REG_OFFSETS);
		chk_w(word, 32'h00000a05);
		$display("test program done");
		foreach (rows[i]) begin
			fork
				for (int k = 0; k < rows[i].ld; k++) begin
					pm.load(dat);
					if (q.size() < 256) q.push_back(dat);
					dat = dat + 18'h0b35d;
				end
				for (int k = 0; k < rows[i].ul; k++) begin
					pm.unload();
					if (q.size() > 0) void'(q.pop_front());
				end
			join
			repeat (3) @(posedge clk_i);
			chk_f(ef(rows[i].cnt, 5, 10));
			axr(dcf_pkg::REG_STATUS);
			chk_w({23'h0, word[8:0]}, {23'h0, rows[i].cnt});
			if (q.size() > 0) chk_w({14'h0, rd}, {14'h0, q[0]});
		end
		$display("test rows done");
		pen_n <= 1'b0;
		repeat (5) @(posedge clk_i);
		pm.load(18'h00033);
		repeat (3) @(posedge clk_i);
		chk_w({14'h0, rd}, 32'h00000033);
		axr(dcf_pkg::REG_OFFSETS);
		chk_w(word, 32'h00000a05);
		pen_n <= 1'b1;
		axw(dcf_pkg::REG_CTRL, 32'h00000001);
		chk_w({30'h0, resp}, {30'h0, dcf_pkg::RESP_OKAY});
		repeat (3) @(posedge clk_i);
		chk_f(ef(0, 64, 64));
		axr(dcf_pkg::REG_OFFSETS);
		chk_w(word, 32'h00004040);
		axw(dcf_pkg::REG_STATUS, 32'h00000001);
		chk_w({30'h0, resp}, {30'h0, dcf_pkg::RESP_SLVERR});
		axr(8'h0c);
		chk_w({resp, word[29:0]}, {dcf_pkg::RESP_SLVERR, 30'h0});
		oe_n <= 1'b1;
		repeat (6) @(posedge clk_i);
		chk_w({31'h0, oe}, 32'h00000000);
		$display("test tail done");
		conclude();
	end
endmodule
